/* sfp_pkg.sv */
// Constants and types shared by the serial flash pin front end and its FIFO.
// Assumes a SystemVerilog tool; nothing here depends on the surrounding chip.
package sfp_pkg;

  // ==========================================================================
  // Widths and depths
  localparam int SFP_BYTE_W = 8;
  localparam int SFP_FIFO_DEPTH = 8;
  localparam int SFP_TX_W = SFP_BYTE_W + 2;

  // ==========================================================================
  // Lane modes carried with every outgoing byte
  typedef enum logic [1:0] {
    SFP_LANE_1 = 2'b00,
    SFP_LANE_2 = 2'b01,
    SFP_LANE_4 = 2'b10
  } sfp_lanes_t;

  // ==========================================================================
  // Bit counting on the receive side
  localparam logic [2:0] SFP_RX_STEP_1 = 3'h1;
  localparam logic [2:0] SFP_RX_STEP_4 = 3'h4;
  localparam logic [2:0] SFP_RX_LAST_1 = 3'h7;
  localparam logic [2:0] SFP_RX_LAST_4 = 3'h4;

  // Shifts remaining after a byte is loaded on the transmit side.
  localparam logic [2:0] SFP_TX_LEFT_1 = 3'h7;
  localparam logic [2:0] SFP_TX_LEFT_2 = 3'h3;
  localparam logic [2:0] SFP_TX_LEFT_4 = 3'h1;

  // ==========================================================================
  // Values after reset
  localparam logic [2:0] SFP_CNT_RST = 3'h0;
  localparam logic [7:0] SFP_SH_RST = 8'h00;
  localparam logic SFP_SEL_N_RST = 1'b1;
  localparam logic SFP_LOCK_N_RST = 1'b1;
  localparam logic SFP_STANDBY_RST = 1'b1;
  localparam logic SFP_PULSE_RST = 1'b0;

endpackage

/* sfp_stream_if.sv */
// Valid/ready word stream between the front end and its FIFOs.
// Assumes the producer holds data stable while valid is high and ready is low.
`timescale 1ns/1ns
interface sfp_stream_if #(
  parameter int WIDTH = 8
) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // sfp_stream_if

/* sfp_async_fifo.sv */
// Dual-clock FIFO with gray-coded pointers, valid/ready on both sides.
// Assumes DEPTH is a power of two and at least 4; both resets are asynchronous.
`timescale 1ns/1ns
module sfp_async_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk,
  input wire logic wr_arst,
  sfp_stream_if.snk wr,
  input wire logic rd_clk,
  input wire logic rd_arst,
  sfp_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin, next_wbin, wgray, next_wgray, rg_meta, rg_sync;
  logic [AW:0] rbin, next_rbin, rgray, next_rgray, wg_meta, wg_sync;
  logic wr_fire, rd_fire;

  // ==========================================================================
  // Write side
  always_comb begin
    wr.ready = (wgray != {~rg_sync[AW:AW-1], rg_sync[AW-2:0]});
    wr_fire = wr.valid & wr.ready;
    next_wbin = wbin + {{AW{1'b0}}, wr_fire};
    next_wgray = next_wbin ^ (next_wbin >> 1);
  end

  always_ff @(posedge wr_clk or posedge wr_arst) begin
    if (wr_arst) begin
      wbin <= '0;
      wgray <= '0;
      rg_meta <= '0;
      rg_sync <= '0;
    end else begin
      wbin <= next_wbin;
      wgray <= next_wgray;
      rg_meta <= rgray;
      rg_sync <= rg_meta;
    end
  end

  // The array has no reset; a word is only read after its pointer has crossed.
  always_ff @(posedge wr_clk) begin
    if (wr_fire) begin
      mem[wbin[AW-1:0]] <= wr.data;
    end
  end

  // ==========================================================================
  // Read side
  always_comb begin
    rd.valid = (rgray != wg_sync);
    rd.data = mem[rbin[AW-1:0]];
    rd_fire = rd.valid & rd.ready;
    next_rbin = rbin + {{AW{1'b0}}, rd_fire};
    next_rgray = next_rbin ^ (next_rbin >> 1);
  end

  always_ff @(posedge rd_clk or posedge rd_arst) begin
    if (rd_arst) begin
      rbin <= '0;
      rgray <= '0;
      wg_meta <= '0;
      wg_sync <= '0;
    end else begin
      rbin <= next_rbin;
      rgray <= next_rgray;
      wg_meta <= wgray;
      wg_sync <= wg_meta;
    end
  end

endmodule // sfp_async_fifo

/* sfp_pin_front.sv */
// Serial pin front end of a serial flash: select framing, lane shifting, pin drive.
// Assumes the command decoder sits on core_clk and pushes read bytes only when due.
//
// What this block does
// - An operation starts at select falling and ends at select rising; only those.
// - Selected only while select is low; deselect normally enters standby.
// - Deselect during a self-timed program or erase delays standby until done.
// - Command, address and write data are captured on serial clock rising edges.
// - Read data changes on falling edges so the host samples it on rising ones.
// - While deselected, the serial input is ignored and no bits are captured.
// - While deselected, the serial output floats.
// - Dual reads drive two bits per falling edge on lanes zero and one.
// - Quad reads drive four bits per falling edge on all four lanes.
// - Quad program captures four bits per rising edge, lane two among them.
// - Outside quad transfers, pause freezes clock and input, floats the output; internal work goes on.
`timescale 1ns/1ns
module sfp_pin_front #(
  parameter int FIFO_DEPTH = sfp_pkg::SFP_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic serial_in_dq0,
  output logic serial_in_dq0_drv,
  output logic serial_in_dq0_oe,
  input wire logic serial_out_dq1,
  output logic serial_out_dq1_drv,
  output logic serial_out_dq1_oe,
  input wire logic write_protect_dq2,
  output logic write_protect_dq2_drv,
  output logic write_protect_dq2_oe,
  input wire logic pause_n_dq3,
  output logic pause_n_dq3_drv,
  output logic pause_n_dq3_oe,
  input wire logic busy,
  input wire logic quad_in,
  output logic [sfp_pkg::SFP_BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [sfp_pkg::SFP_BYTE_W-1:0] tx_data,
  input wire sfp_pkg::sfp_lanes_t tx_lanes,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic selected,
  output logic standby,
  output logic frame_start,
  output logic frame_end,
  output logic lock_n
);
  import sfp_pkg::*;

  // ==========================================================================
  // Core clock domain: pin synchronisers and frame status
  logic rst_q, next_rst_q;
  logic cs_meta, next_cs_meta, cs_sync, next_cs_sync, cs_prev, next_cs_prev;
  logic wp_meta, next_wp_meta, next_lock_n;
  logic next_selected, next_standby, next_frame_start, next_frame_end;

  always_comb begin
    next_rst_q = rst;
    if (rst) begin
      next_cs_meta = SFP_SEL_N_RST;
      next_cs_sync = SFP_SEL_N_RST;
      next_cs_prev = SFP_SEL_N_RST;
      next_wp_meta = SFP_LOCK_N_RST;
      next_lock_n = SFP_LOCK_N_RST;
      next_selected = ~SFP_SEL_N_RST;
      next_standby = SFP_STANDBY_RST;
      next_frame_start = SFP_PULSE_RST;
      next_frame_end = SFP_PULSE_RST;
    end else begin
      next_cs_meta = select_n;
      next_cs_sync = cs_meta;
      next_cs_prev = cs_sync;
      next_wp_meta = write_protect_dq2;
      // During quad input lane two carries data, so its level says nothing about locking.
      next_lock_n = quad_in ? lock_n : wp_meta;
      next_selected = ~cs_sync;
      next_standby = cs_sync & ~busy;
      next_frame_start = cs_prev & ~cs_sync;
      next_frame_end = ~cs_prev & cs_sync;
    end
  end

  always_ff @(posedge core_clk) begin
    rst_q <= next_rst_q;
    cs_meta <= next_cs_meta;
    cs_sync <= next_cs_sync;
    cs_prev <= next_cs_prev;
    wp_meta <= next_wp_meta;
    lock_n <= next_lock_n;
    selected <= next_selected;
    standby <= next_standby;
    frame_start <= next_frame_start;
    frame_end <= next_frame_end;
  end

  // ==========================================================================
  // Streams and FIFOs between the two domains
  sfp_stream_if #(.WIDTH(SFP_BYTE_W)) rx_in ();
  sfp_stream_if #(.WIDTH(SFP_BYTE_W)) rx_out ();
  sfp_stream_if #(.WIDTH(SFP_TX_W)) tx_in ();
  sfp_stream_if #(.WIDTH(SFP_TX_W)) tx_out ();

  logic link_clr, serial_clk_n;
  assign link_clr = select_n | rst_q;
  assign serial_clk_n = ~serial_clk;

  // The link side resets asynchronously because the serial clock may be stopped.
  sfp_async_fifo #(.WIDTH(SFP_BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .wr_clk(serial_clk),
    .wr_arst(rst_q),
    .wr(rx_in),
    .rd_clk(core_clk),
    .rd_arst(rst_q),
    .rd(rx_out)
  );

  sfp_async_fifo #(.WIDTH(SFP_TX_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .wr_clk(core_clk),
    .wr_arst(rst_q),
    .wr(tx_in),
    .rd_clk(serial_clk_n),
    .rd_arst(rst_q),
    .rd(tx_out)
  );

  assign rx_data = rx_out.data;
  assign rx_valid = rx_out.valid;
  assign rx_out.ready = rx_ready;
  assign tx_in.data = {tx_lanes, tx_data};
  assign tx_in.valid = tx_valid;
  assign tx_ready = tx_in.ready;

  // ==========================================================================
  // Link domain, rising edges: capture
  logic qin_meta, qin_sync;
  logic [7:0] rx_sh, next_rx_sh;
  logic [2:0] rx_cnt, next_rx_cnt;
  logic rx_hold, rx_done, rx_push, pause_now, tx_act, tx_quad;
  sfp_lanes_t tx_mode;

  always_ff @(posedge serial_clk or posedge rst_q) begin
    if (rst_q) begin
      qin_meta <= 1'b0;
      qin_sync <= 1'b0;
    end else begin
      qin_meta <= quad_in;
      qin_sync <= qin_meta;
    end
  end

  always_comb begin
    tx_quad = tx_act & (tx_mode == SFP_LANE_4);
    // Lane three is a pause input only when no quad transfer owns it.
    pause_now = ~pause_n_dq3 & ~qin_sync & ~tx_quad;
    // A full receive FIFO stalls capture; the host cannot be held off.
    rx_hold = pause_now | tx_act | ~rx_in.ready;
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    if (qin_sync) begin
      next_rx_sh = {rx_sh[3:0], pause_n_dq3, write_protect_dq2, serial_out_dq1, serial_in_dq0};
      rx_done = (rx_cnt == SFP_RX_LAST_4);
    end else begin
      next_rx_sh = {rx_sh[6:0], serial_in_dq0};
      rx_done = (rx_cnt == SFP_RX_LAST_1);
    end
    if (rx_hold) begin
      next_rx_sh = rx_sh;
    end else begin
      next_rx_cnt = rx_cnt + (qin_sync ? SFP_RX_STEP_4 : SFP_RX_STEP_1);
    end
    // The finished byte is written on the same edge: no later edge is promised.
    rx_push = rx_done & ~rx_hold & ~select_n;
    rx_in.valid = rx_push;
    rx_in.data = next_rx_sh;
  end

  // Select high clears the frame at once, so deselected input is never captured.
  always_ff @(posedge serial_clk or posedge link_clr) begin
    if (link_clr) begin
      rx_sh <= SFP_SH_RST;
      rx_cnt <= SFP_CNT_RST;
    end else begin
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
    end
  end

  // ==========================================================================
  // Link domain, falling edges: drive
  logic [7:0] tx_sh, next_tx_sh;
  logic [2:0] tx_left, next_tx_left;
  logic next_tx_act, tx_load;
  sfp_lanes_t next_tx_mode, load_mode;

  always_comb begin
    load_mode = sfp_lanes_t'(tx_out.data[SFP_TX_W-1:SFP_BYTE_W]);
    next_tx_sh = tx_sh;
    next_tx_left = tx_left;
    next_tx_mode = tx_mode;
    next_tx_act = tx_act;
    tx_load = 1'b0;
    if (!pause_now) begin
      if (tx_left != SFP_CNT_RST) begin
        next_tx_left = tx_left - 3'h1;
        case (tx_mode)
          SFP_LANE_2: next_tx_sh = {tx_sh[5:0], 2'h0};
          SFP_LANE_4: next_tx_sh = {tx_sh[3:0], 4'h0};
          default: next_tx_sh = {tx_sh[6:0], 1'b0};
        endcase
      end else if (tx_out.valid) begin
        tx_load = 1'b1;
        next_tx_sh = tx_out.data[SFP_BYTE_W-1:0];
        next_tx_mode = load_mode;
        next_tx_act = 1'b1;
        case (load_mode)
          SFP_LANE_2: next_tx_left = SFP_TX_LEFT_2;
          SFP_LANE_4: next_tx_left = SFP_TX_LEFT_4;
          default: next_tx_left = SFP_TX_LEFT_1;
        endcase
      end else begin
        // Nothing queued at a byte boundary: stop driving rather than repeat data.
        next_tx_act = 1'b0;
      end
    end
    tx_out.ready = tx_load;
  end

  always_ff @(negedge serial_clk or posedge link_clr) begin
    if (link_clr) begin
      tx_sh <= SFP_SH_RST;
      tx_left <= SFP_CNT_RST;
      tx_mode <= SFP_LANE_1;
      tx_act <= 1'b0;
    end else begin
      tx_sh <= next_tx_sh;
      tx_left <= next_tx_left;
      tx_mode <= next_tx_mode;
      tx_act <= next_tx_act;
    end
  end

  // ==========================================================================
  // Pin drive: enables fall with select at once, not after a clock edge
  logic drive_ok;
  always_comb begin
    drive_ok = ~select_n & tx_act & ~pause_now;
    serial_in_dq0_drv = 1'b0;
    serial_out_dq1_drv = tx_sh[7];
    write_protect_dq2_drv = 1'b0;
    pause_n_dq3_drv = 1'b0;
    case (tx_mode)
      SFP_LANE_2: serial_in_dq0_drv = tx_sh[6];
      SFP_LANE_4: begin
        pause_n_dq3_drv = tx_sh[7];
        write_protect_dq2_drv = tx_sh[6];
        serial_out_dq1_drv = tx_sh[5];
        serial_in_dq0_drv = tx_sh[4];
      end
      default: serial_in_dq0_drv = 1'b0;
    endcase
    serial_out_dq1_oe = drive_ok;
    serial_in_dq0_oe = drive_ok & (tx_mode != SFP_LANE_1);
    write_protect_dq2_oe = drive_ok & (tx_mode == SFP_LANE_4);
    pause_n_dq3_oe = drive_ok & (tx_mode == SFP_LANE_4);
  end

  // ==========================================================================
  // Checks
  sequence sel_fall;
    $fell(cs_sync);
  endsequence

  sequence sel_rise;
    $rose(cs_sync);
  endsequence

  sequence desel_busy;
    cs_sync && busy;
  endsequence

  frame_open_a: assert property (@(posedge core_clk) disable iff (rst) sel_fall |=> frame_start)
    else $error("frame start missing after select fell");
  frame_close_a: assert property (@(posedge core_clk) disable iff (rst) sel_rise |=> frame_end && !frame_start)
    else $error("frame end missing after select rose");
  select_level_a: assert property (@(posedge core_clk) disable iff (rst) !cs_sync ##1 !cs_sync |-> selected)
    else $error("selected low while select held low");
  standby_wait_a: assert property (@(posedge core_clk) disable iff (rst) desel_busy |=> !standby)
    else $error("standby entered while busy");
  standby_enter_a: assert property (@(posedge core_clk) disable iff (rst) (cs_sync && !busy) |=> standby)
    else $error("standby not entered when deselected and idle");
  deselect_ignore_a: assert property (@(posedge core_clk) disable iff (rst) select_n |-> !rx_in.valid)
    else $error("byte captured while deselected");
  deselect_float_a: assert property (@(posedge core_clk) disable iff (rst)
    select_n |-> !(serial_in_dq0_oe || serial_out_dq1_oe || write_protect_dq2_oe || pause_n_dq3_oe))
    else $error("pin driven while deselected");
  single_capture_a: assert property (@(posedge serial_clk) disable iff (link_clr)
    (rx_push && !qin_sync && !$past(rx_hold)) |-> rx_in.data[1] == $past(serial_in_dq0))
    else $error("single lane bit not captured on rising edge");
  quad_capture_a: assert property (@(posedge serial_clk) disable iff (link_clr)
    (rx_push && qin_sync && $past(qin_sync) && !$past(rx_hold)) |->
    rx_in.data[7:4] == $past({pause_n_dq3, write_protect_dq2, serial_out_dq1, serial_in_dq0}))
    else $error("quad nibble not captured on rising edge");
  pause_freeze_a: assert property (@(posedge serial_clk) disable iff (link_clr)
    pause_now |-> !serial_out_dq1_oe ##1 rx_cnt == $past(rx_cnt))
    else $error("pause did not freeze capture or float output");
  single_shift_a: assert property (@(negedge serial_clk) disable iff (link_clr)
    (tx_act && tx_mode == SFP_LANE_1 && tx_left != 3'h0 && !pause_now) |=> serial_out_dq1_drv == $past(tx_sh[6]))
    else $error("output bit did not advance on falling edge");
  dual_lanes_a: assert property (@(negedge serial_clk) disable iff (link_clr)
    (tx_act && tx_mode == SFP_LANE_2 && !pause_now) |->
    serial_in_dq0_oe && serial_out_dq1_oe && !write_protect_dq2_oe && !pause_n_dq3_oe)
    else $error("dual read lane enables wrong");
  quad_lanes_a: assert property (@(negedge serial_clk) disable iff (link_clr)
    (tx_act && tx_mode == SFP_LANE_4) |->
    serial_in_dq0_oe && serial_out_dq1_oe && write_protect_dq2_oe && pause_n_dq3_oe)
    else $error("quad read lane enables wrong");
  msb_first_a: assert property (@(negedge serial_clk) disable iff (link_clr)
    (tx_load && load_mode == SFP_LANE_4) |=>
    {pause_n_dq3_drv, write_protect_dq2_drv, serial_out_dq1_drv, serial_in_dq0_drv} == $past(tx_out.data[7:4]))
    else $error("quad byte not sent high nibble first");

endmodule // sfp_pin_front

/* sfp_host_model.sv */
// Host serial controller model: frames, clocks and drives the flash pins.
// Assumes the bench resolves pin levels and returns {device enables, levels}.
`timescale 1ns/1ns
module sfp_host_model (
  output logic serial_clk,
  output logic select_n,
  output logic [3:0] h_drv,
  output logic [3:0] h_oe,
  input wire logic [7:0] pin
);
  int frames = 0;
  initial begin
    serial_clk = 1'b0;
    h_drv = 4'hc;
    h_oe = 4'hc;
    // Select rises just after time zero so that its edge surely clears the link logic.
    #1 select_n = 1'b1;
  end
  // ======
  // Framing; the serial clock stands still outside frames.
  task automatic frame(input logic on);
    if (on) frames++;
    #32 select_n = ~on;
    #32;
  endtask
  task automatic set_wp(input logic v);
    h_drv[2] = v;
  endtask
  // One clock period; the host samples on the rising edge.
  task automatic shift(input logic [3:0] v, input logic [3:0] oe, output logic [7:0] got);
    h_drv = v;
    h_oe = oe;
    #32 serial_clk = 1'b1;
    got = pin;
    #32 serial_clk = 1'b0;
  endtask
  // Pause with junk on the clock and lane zero, which must be ignored.
  task automatic pause(input int n);
    if (!select_n && !serial_clk) begin
      h_oe = 4'hd;
      h_drv = 4'h4;
      repeat (n) begin
        #32 serial_clk = 1'b1;
        h_drv[0] = ~h_drv[0];
        #32 serial_clk = 1'b0;
      end
      h_drv[3] = 1'b1;
      #32;
    end
  endtask
endmodule // sfp_host_model

/* tb.sv */
// Self-checking bench for the serial flash pin front end.
// Assumes the package, FIFO, interface, front end and host model are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import sfp_pkg::*;
  logic core_clk = 1'b0, tog = 1'b0, rst, busy, quad_in, rx_ready, tx_valid;
  logic [7:0] tx_data, rx_data;
  sfp_lanes_t tx_lanes;
  logic rx_valid, tx_ready, selected, standby, frame_start, frame_end, lock_n, serial_clk, select_n;
  logic [3:0] h_drv, h_oe, drv, oe, pin;
  logic [7:0] wq[$], got_q[$];
  int num_errors = 0, checks_done = 0, n_fs = 0, n_fe = 0;
  always #50 core_clk = ~core_clk;
  always #16 tog = ~tog;
  // Device enable wins, then host; lanes 2-3 are pulled up, lanes 0-1 show a moving pattern.
  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign pin[i] = oe[i] ? drv[i] : h_oe[i] ? h_drv[i] : (i > 1) ? 1'b1 : tog;
  end
  sfp_pin_front #(.FIFO_DEPTH(8)) sfp_pin_front_inst (
    .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk), .select_n(select_n),
    .serial_in_dq0(pin[0]), .serial_in_dq0_drv(drv[0]), .serial_in_dq0_oe(oe[0]),
    .serial_out_dq1(pin[1]), .serial_out_dq1_drv(drv[1]), .serial_out_dq1_oe(oe[1]),
    .write_protect_dq2(pin[2]), .write_protect_dq2_drv(drv[2]), .write_protect_dq2_oe(oe[2]),
    .pause_n_dq3(pin[3]), .pause_n_dq3_drv(drv[3]), .pause_n_dq3_oe(oe[3]),
    .busy(busy), .quad_in(quad_in), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_lanes(tx_lanes), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .selected(selected), .standby(standby), .frame_start(frame_start), .frame_end(frame_end),
    .lock_n(lock_n)
  );
  sfp_host_model sfp_host_model_inst (
    .serial_clk(serial_clk), .select_n(select_n), .h_drv(h_drv), .h_oe(h_oe), .pin({oe, pin})
  );
  // Sampled at the falling edge, where the FIFO outputs have settled for the next rising edge.
  always @(negedge core_clk) begin
    if (rx_valid === 1'b1 && rx_ready) got_q.push_back(rx_data);
    if (frame_start === 1'b1) n_fs++;
    if (frame_end === 1'b1) n_fe++;
  end
  always @(negedge core_clk) begin
    if (select_n) `CHK(oe, 4'h0)
    `CHK(oe & h_oe, 4'h0)
  end
  // ======
  // Expectations
  function automatic logic [3:0] grp(input logic [7:0] b, input logic [1:0] w, input int j);
    logic [7:0] s;
    s = b << (j << w);
    return s[7:4] >> (4 - (1 << w));
  endfunction
  function automatic logic [3:0] oem(input logic [1:0] w);
    return (w == 2'd0) ? 4'h2 : (w == 2'd1) ? 4'h3 : 4'hf;
  endfunction
  // ======
  // Drivers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic push(input logic [7:0] b, input logic [1:0] w);
    int k;
    logic rdy;
    k = 0;
    tx_data = b;
    tx_lanes = sfp_lanes_t'(w);
    tx_valid = 1'b1;
    do begin
      // Ready only moves on rising edges, so its level at the falling edge is the one taken.
      @(negedge core_clk);
      rdy = tx_ready;
      @(posedge core_clk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    #1;
    if (k >= 50) num_errors++;
  endtask
  task automatic wr_frame(input logic [1:0] w, input int nb, input int pz);
    logic [7:0] g;
    logic [3:0] v;
    sfp_host_model_inst.frame(1'b1);
    for (int i = 0; i < nb; i++) begin
      for (int j = 0; j < (8 >> w); j++) begin
        v = grp(wq[i], w, j);
        if (i * 8 + j == pz) sfp_host_model_inst.pause(3);
        sfp_host_model_inst.shift((w == 2'd0) ? {3'b110, v[0]} : v, (w == 2'd0) ? 4'hd : 4'hf, g);
      end
    end
    sfp_host_model_inst.frame(1'b0);
  endtask
  task automatic rd_frame(input logic [1:0] w, input int nb);
    logic [7:0] g, acc;
    int n, k;
    n = 0;
    acc = 8'h00;
    sfp_host_model_inst.frame(1'b1);
    for (k = 0; k < 200 && n < nb * 8; k++) begin
      sfp_host_model_inst.shift(4'h0, 4'h0, g);
      if (g[5] === 1'b1) begin
        `CHK(g[7:4], oem(w))
        acc = (w == 2'd0) ? {acc[6:0], g[1]} : (w == 2'd1) ? {acc[5:0], g[1:0]} : {acc[3:0], g[3:0]};
        n += 1 << w;
        if (n % 8 == 0) got_q.push_back(acc);
      end
    end
    sfp_host_model_inst.frame(1'b0);
  endtask
  // Quad mode crosses into the link domain only on serial clock edges, so a
  // throwaway frame flushes the old mode; whatever it captured is dropped.
  task automatic settle(input logic q);
    quad_in = q;
    cyc(3);
    wq.push_back(8'hff);
    wr_frame(q ? 2'd2 : 2'd0, 1, -1);
    cyc(12);
    wq.delete();
    got_q.delete();
  endtask
  task automatic check_q;
    `CHK(got_q.size(), wq.size())
    foreach (wq[i]) if (i < got_q.size()) `CHK(got_q[i], wq[i])
    wq.delete();
    got_q.delete();
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ======
  // Scenarios
  initial begin
    rst = 1'b1;
    {busy, quad_in, rx_ready, tx_valid} = 4'h2;
    void'($urandom(88));
    tx_data = 8'($urandom);
    tx_lanes = SFP_LANE_1;
    cyc(20);
    rst = 1'b0;
    cyc(2);
    `CHK({selected, standby, lock_n, tx_ready, rx_valid}, 5'b01110)
    sfp_host_model_inst.set_wp(1'b0);
    cyc(5);
    `CHK(lock_n, 1'b0)
    sfp_host_model_inst.set_wp(1'b1);
    cyc(5);
    `CHK(lock_n, 1'b1)
    repeat (4) wq.push_back(8'($urandom));
    wq[0] = 8'h80;
    wr_frame(2'd0, 4, 13);
    cyc(12);
    check_q;
    settle(1'b1);
    repeat (3) wq.push_back(8'($urandom));
    wr_frame(2'd2, 3, -1);
    cyc(12);
    check_q;
    `CHK(lock_n, 1'b1)
    settle(1'b0);
    rx_ready = 1'b0;
    repeat (9) wq.push_back(8'($urandom));
    wr_frame(2'd0, 9, -1);
    void'(wq.pop_back());
    cyc(12);
    repeat (40) begin
      rx_ready = 1'($urandom);
      cyc(1);
    end
    rx_ready = 1'b1;
    cyc(10);
    check_q;
    busy = 1'b1;
    sfp_host_model_inst.frame(1'b1);
    cyc(5);
    `CHK({selected, standby}, 2'b10)
    sfp_host_model_inst.frame(1'b0);
    cyc(5);
    `CHK({selected, standby}, 2'b00)
    repeat (4) begin
      busy = 1'($urandom);
      cyc(3);
      `CHK(standby, ~busy)
    end
    busy = 1'b0;
    cyc(3);
    `CHK(standby, 1'b1)
    repeat (8) wq.push_back(8'($urandom));
    foreach (wq[i]) push(wq[i], 2'd0);
    tx_valid = 1'b0;
    cyc(3);
    `CHK(tx_ready, 1'b0)
    rd_frame(2'd0, 8);
    cyc(5);
    check_q;
    for (int w = 1; w < 3; w++) begin
      repeat (2) wq.push_back(8'($urandom));
      foreach (wq[i]) push(wq[i], w[1:0]);
      tx_valid = 1'b0;
      cyc(5);
      rd_frame(w[1:0], 2);
      cyc(5);
      check_q;
    end
    `CHK(n_fs, sfp_host_model_inst.frames)
    `CHK(n_fe, sfp_host_model_inst.frames)
    end_sim;
  end
  initial begin
    #3000000;
    num_errors++;
    end_sim;
  end
endmodule // tb
